// File: rtl/lpc_regs.svh
// constants of the lamp pwm and overload block: offsets, fields, resets, timing
// assumes a 125 MHz system clock and a word-wide register port
`ifndef LPC_REGS_SVH
`define LPC_REGS_SVH

`define LPC_CLK_HZ     125000000
`define LPC_PWM_HZ     4000
`define LPC_STEPS      256
`define LPC_PRESCALE   (`LPC_CLK_HZ / (`LPC_PWM_HZ * `LPC_STEPS))
`define LPC_PS_W       7
`define LPC_DUTY_W     8

`define LPC_A_CTRL     8'h00
`define LPC_A_DUTY     8'h04
`define LPC_A_RAMP     8'h08
`define LPC_A_THR      8'h0c
`define LPC_A_STAT     8'h10
`define LPC_A_INT      8'h14
`define LPC_A_MASK     8'h18
`define LPC_A_SAMP     8'h1c

`define LPC_CTRL_OFF   0
`define LPC_CTRL_POL   1

`define LPC_EV_OC      0
`define LPC_EV_FS      1
`define LPC_EV_LL      2
`define LPC_EV_CONV    3
`define LPC_EV_W       4

`define LPC_RST_CTRL   2'h0
`define LPC_RST_DUTY   8'h00
`define LPC_RST_RAMP   8'h01
`define LPC_RST_THR    8'h10
`define LPC_ADC_CHAN   3'h1
`define LPC_FLT_SHIFT  8

`endif

// File: rtl/lpc_pkg.sv
// types shared by the lamp pwm and overload block
// assumes lpc_regs.svh supplies the widths
`include "lpc_regs.svh"

package lpc_pkg;
    typedef logic [`LPC_DUTY_W-1:0] lpc_duty_t;
    typedef logic [`LPC_EV_W-1:0]   lpc_ev_t;
    typedef logic [15:0]            lpc_flt_t;
endpackage : lpc_pkg

// File: rtl/lpc_pwm_core.sv
// prescaler and left-aligned 8-bit pwm counter of the lamp channel
// assumes run is a same-clock level; duty is taken at each period start
`include "lpc_regs.svh"

module lpc_pwm_core (
    input  wire logic              clk,          // system clock
    input  wire logic              rst_b,        // sync reset, active low
    input  wire logic              run,          // counter advances while high
    input  wire lpc_pkg::lpc_duty_t duty,        // requested duty
    output logic                   active,       // active phase of the period
    output logic                   period_start  // one-cycle pulse at period start
);
    // ======================================================
    // prescaler and counter
    logic [`LPC_PS_W-1:0]    ps_r,   ps_nxt;
    lpc_pkg::lpc_duty_t      cnt_r,  cnt_nxt;
    lpc_pkg::lpc_duty_t      dbuf_r, dbuf_nxt;
    logic                    act_r,  act_nxt;
    logic                    st_r,   st_nxt;
    logic                    tick;

    always_comb
    begin
        ps_nxt   = ps_r;
        cnt_nxt  = cnt_r;
        dbuf_nxt = dbuf_r;
        st_nxt   = 1'b0;
        tick     = 1'b0;
        if (run)
        begin
            if (ps_r == `LPC_PS_W'(`LPC_PRESCALE - 1))
            begin
                ps_nxt = '0;
                tick   = 1'b1;
            end
            else
                ps_nxt = ps_r + `LPC_PS_W'(1);
        end
        if (tick)
        begin
            cnt_nxt = cnt_r + `LPC_DUTY_W'(1);
            if (cnt_r == '1)
            begin
                dbuf_nxt = duty;
                st_nxt   = 1'b1;
            end
        end
        // active from the period start until the compare match
        act_nxt = (cnt_nxt < dbuf_nxt);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ps_r   <= '0;
            cnt_r  <= '0;
            dbuf_r <= `LPC_RST_DUTY;
            act_r  <= 1'b0;
            st_r   <= 1'b0;
        end
        else
        begin
            ps_r   <= ps_nxt;
            cnt_r  <= cnt_nxt;
            dbuf_r <= dbuf_nxt;
            act_r  <= act_nxt;
            st_r   <= st_nxt;
        end
    end

    assign active       = act_r;
    assign period_start = st_r;
endmodule : lpc_pwm_core

// File: rtl/lpc_top.sv
// lamp pwm generator with overload shutdown, ramping and open-load check
// assumes an on-chip 8-bit converter on CLK; fault and comparator pins are asynchronous
`include "lpc_regs.svh"

module lpc_top (
    input  wire logic        CLK,          // system clock, 125 MHz
    input  wire logic        RST_B,        // sync reset, active low
    input  wire logic [7:0]  ADDR,         // register byte address
    input  wire logic [31:0] WDATA,        // write data
    input  wire logic        WR,           // write strobe
    input  wire logic        RD,           // read strobe
    output logic      [31:0] RDATA,        // read data, cycle after RD
    output logic             IRQ,          // level interrupt
    input  wire logic        STOP_MODE,    // device in stop state
    input  wire logic        SWITCH_FAULT_N, // switch fault line, active low, async
    input  wire logic        COMP_OVER,    // comparator: sense above reference, async
    output logic             LAMP_PWM,     // lamp channel pin
    output logic             CONV_TRIG,    // conversion trigger pulse
    output logic      [2:0]  CONV_CHAN,    // converter channel select
    input  wire logic        CONV_DONE,    // conversion result valid pulse
    input  wire logic [7:0]  CONV_DATA     // conversion result
);
    // ======================================================
    // pin synchronisers
    logic [1:0] fs_sync_r;
    logic [1:0] oc_sync_r;
    logic       fault_n_s;
    logic       over_s;

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            fs_sync_r <= 2'h3;
            oc_sync_r <= 2'h0;
        end
        else
        begin
            fs_sync_r <= {fs_sync_r[0], SWITCH_FAULT_N};
            oc_sync_r <= {oc_sync_r[0], COMP_OVER};
        end
    end

    // fault line resets to its idle high level, so no false failure follows reset
    assign fault_n_s = fs_sync_r[1];
    assign over_s    = oc_sync_r[1];

    // ======================================================
    // pwm core
    lpc_pkg::lpc_duty_t duty_app_r;
    logic               core_act;
    logic               core_start;

    // the core takes the duty only at its wrap, so a ramp step lands one period later
    lpc_pwm_core lpc_pwm_core_i (
        .clk          (CLK),
        .rst_b        (RST_B),
        .run          (!STOP_MODE),
        .duty         (duty_app_r),
        .active       (core_act),
        .period_start (core_start)
    );

    // ======================================================
    // registers, protection, ramp and diagnostics
    logic               off_r,      off_nxt;
    logic               pol_r,      pol_nxt;
    lpc_pkg::lpc_duty_t duty_cmd_r, duty_cmd_nxt;
    lpc_pkg::lpc_duty_t ramp_r,     ramp_nxt;
    lpc_pkg::lpc_duty_t thr_r,      thr_nxt;
    lpc_pkg::lpc_ev_t   ist_r,      ist_nxt;
    lpc_pkg::lpc_ev_t   mask_r,     mask_nxt;
    lpc_pkg::lpc_duty_t duty_app_nxt;
    lpc_pkg::lpc_duty_t div_r,      div_nxt;
    lpc_pkg::lpc_duty_t raw_r,      raw_nxt;
    lpc_pkg::lpc_flt_t  flt_r,      flt_nxt;
    logic               ll_r,       ll_nxt;
    logic               pend_r,     pend_nxt;
    logic               on_d_r,     on_d_nxt;
    logic               lamp_r,     lamp_nxt;
    logic               trig_r,     trig_nxt;
    logic [31:0]        rdata_r,    rdata_nxt;
    logic               force_off;
    logic               lamp_on;
    lpc_pkg::lpc_ev_t   ev;
    lpc_pkg::lpc_ev_t   w1c;

    // shutdown holds while either fault is present or the flag is set
    assign force_off = off_r || over_s || !fault_n_s;
    assign lamp_on   = core_act && !force_off;

    always_comb
    begin
        ev          = '0;
        w1c         = '0;
        off_nxt     = off_r;
        pol_nxt     = pol_r;
        duty_cmd_nxt = duty_cmd_r;
        ramp_nxt    = ramp_r;
        thr_nxt     = thr_r;
        mask_nxt    = mask_r;
        duty_app_nxt = duty_app_r;
        div_nxt     = div_r;
        raw_nxt     = raw_r;
        flt_nxt     = flt_r;
        ll_nxt      = ll_r;
        pend_nxt    = pend_r;

        // register writes
        if (WR)
        begin
            unique case (ADDR)
                `LPC_A_CTRL:
                begin
                    off_nxt = WDATA[`LPC_CTRL_OFF];
                    pol_nxt = WDATA[`LPC_CTRL_POL];
                end
                `LPC_A_DUTY: duty_cmd_nxt = WDATA[`LPC_DUTY_W-1:0];
                `LPC_A_RAMP: ramp_nxt     = WDATA[`LPC_DUTY_W-1:0];
                `LPC_A_THR:  thr_nxt      = WDATA[`LPC_DUTY_W-1:0];
                `LPC_A_INT:  w1c          = WDATA[`LPC_EV_W-1:0];
                `LPC_A_MASK: mask_nxt     = WDATA[`LPC_EV_W-1:0];
                default:     ;
            endcase
        end

        // faults set the off flag after the write, so a fault wins
        if (over_s)
        begin
            off_nxt        = 1'b1;
            ev[`LPC_EV_OC] = 1'b1;
        end
        if (!fault_n_s)
        begin
            off_nxt        = 1'b1;
            ev[`LPC_EV_FS] = 1'b1;
        end

        // soft start: applied duty restarts from zero after any shutdown
        if (force_off)
        begin
            duty_app_nxt = '0;
            div_nxt      = '0;
        end
        else if (core_start)
        begin
            if (duty_app_r == duty_cmd_r)
                div_nxt = '0;
            else if (div_r + `LPC_DUTY_W'(1) >= ramp_r)
            begin
                div_nxt = '0;
                if (duty_app_r < duty_cmd_r)
                    duty_app_nxt = duty_app_r + `LPC_DUTY_W'(1);
                else
                    duty_app_nxt = duty_app_r - `LPC_DUTY_W'(1);
            end
            else
                div_nxt = div_r + `LPC_DUTY_W'(1);
        end

        if (trig_nxt)
            pend_nxt = 1'b1;
        // results are taken only for a triggered conversion
        if (CONV_DONE && pend_r)
        begin
            pend_nxt         = 1'b0;
            raw_nxt          = CONV_DATA;
            flt_nxt          = flt_r - (flt_r >> `LPC_FLT_SHIFT) + {8'h00, CONV_DATA};
            ev[`LPC_EV_CONV] = 1'b1;
            // evaluate only while the load is driven
            if (!force_off && duty_app_r != '0)
                ll_nxt = (flt_nxt[15:8] < thr_r);
        end
        if (ll_nxt && !ll_r)
            ev[`LPC_EV_LL] = 1'b1;

        // sticky status: a new event wins over a clearing write
        ist_nxt = (ist_r & ~w1c) | ev;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            off_r      <= 1'(`LPC_RST_CTRL >> `LPC_CTRL_OFF);
            pol_r      <= 1'b0;
            duty_cmd_r <= `LPC_RST_DUTY;
            ramp_r     <= `LPC_RST_RAMP;
            thr_r      <= `LPC_RST_THR;
            ist_r      <= '0;
            mask_r     <= '0;
            duty_app_r <= `LPC_RST_DUTY;
            div_r      <= '0;
            raw_r      <= '0;
            flt_r      <= '0;
            ll_r       <= 1'b0;
            pend_r     <= 1'b0;
        end
        else
        begin
            off_r      <= off_nxt;
            pol_r      <= pol_nxt;
            duty_cmd_r <= duty_cmd_nxt;
            ramp_r     <= ramp_nxt;
            thr_r      <= thr_nxt;
            ist_r      <= ist_nxt;
            mask_r     <= mask_nxt;
            duty_app_r <= duty_app_nxt;
            div_r      <= div_nxt;
            raw_r      <= raw_nxt;
            flt_r      <= flt_nxt;
            ll_r       <= ll_nxt;
            pend_r     <= pend_nxt;
        end
    end

    // ======================================================
    // pin output and conversion trigger
    always_comb
    begin
        // conversion start on the rising edge of the channel output
        trig_nxt = lamp_on && !on_d_r;
        on_d_nxt = lamp_on;
        // pin output: inverted polarity idles high
        lamp_nxt = pol_r ? lamp_on : !lamp_on;
    end

    // pin and trigger are registered together, so the trigger sits on the pin edge
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            on_d_r <= 1'b0;
            lamp_r <= 1'b1;
            trig_r <= 1'b0;
        end
        else
        begin
            on_d_r <= on_d_nxt;
            lamp_r <= lamp_nxt;
            trig_r <= trig_nxt;
        end
    end

    // ======================================================
    // register read port
    always_comb
    begin
        rdata_nxt = '0;
        // status bits show the synchronised pin levels, not the latched off flag
        if (RD)
        begin
            unique case (ADDR)
                `LPC_A_CTRL: rdata_nxt = {30'h0, pol_r, off_r};
                `LPC_A_DUTY: rdata_nxt = {24'h0, duty_cmd_r};
                `LPC_A_RAMP: rdata_nxt = {24'h0, ramp_r};
                `LPC_A_THR:  rdata_nxt = {24'h0, thr_r};
                `LPC_A_STAT: rdata_nxt = {20'h0, !fault_n_s, over_s, ll_r, pend_r,
                                          duty_app_r};
                `LPC_A_INT:  rdata_nxt = {28'h0, ist_r};
                `LPC_A_MASK: rdata_nxt = {28'h0, mask_r};
                `LPC_A_SAMP: rdata_nxt = {8'h0, flt_r, raw_r};
                default:     rdata_nxt = '0;
            endcase
        end
    end

    // read data stands one cycle after the strobe, then drops to zero
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
            rdata_r <= '0;
        else
            rdata_r <= rdata_nxt;
    end

    // ======================================================
    // outputs
    assign RDATA     = rdata_r;
    // level interrupt from registered status and mask
    assign IRQ       = |(ist_r & mask_r);
    assign LAMP_PWM  = lamp_r;
    assign CONV_TRIG = trig_r;
    assign CONV_CHAN = `LPC_ADC_CHAN;
endmodule : lpc_top

// File: verif/lpc_sva.sv
// assertions on the ports of the lamp pwm block
// assumes one clock CLK and sync reset RST_B; the bind is at the foot
// ==================================================================
// checker
module lpc_sva (
    input wire logic       CLK,            // clock
    input wire logic       RST_B,          // reset, active low
    input wire logic       WR,             // write strobe
    input wire logic       STOP_MODE,      // stop state
    input wire logic       SWITCH_FAULT_N, // switch fault line
    input wire logic       COMP_OVER,      // comparator output
    input wire logic       LAMP_PWM,       // lamp pin
    input wire logic       CONV_TRIG,      // conversion trigger
    input wire logic [2:0] CONV_CHAN       // channel select
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] gap_r; // cycles since the last trigger, saturating

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // a write may re-enable mid-period, so it sets the gap count to its saturated value
    always_ff @(posedge CLK)
        if (!RST_B || WR)
            gap_r <= 16'hffff;
        else if (CONV_TRIG)
            gap_r <= 16'h0000;
        else if (gap_r != 16'hffff)
            gap_r <= gap_r + 16'h0001;

    property p_rst_idle; $past(RST_B) == 1'b0 |-> LAMP_PWM && !CONV_TRIG; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("pin active after reset");
    property p_chan; CONV_CHAN == 3'h1; endproperty
    a_chan: assert property (p_chan) else $error("channel select moved");
    property p_trig;
        CONV_TRIG |-> (LAMP_PWM != $past(LAMP_PWM) || $past(LAMP_PWM) != $past(LAMP_PWM, 2))
            ##1 !CONV_TRIG;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger away from pwm edge");
    property p_gap; CONV_TRIG |-> gap_r >= 16'h79ff; endproperty
    a_gap: assert property (p_gap) else $error("triggers closer than a period");
    property p_over; (COMP_OVER && !WR) [*5] |-> $stable(LAMP_PWM) && !CONV_TRIG; endproperty
    a_over: assert property (p_over) else $error("pin moves under overcurrent");
    property p_fault;
        (!SWITCH_FAULT_N && !WR) [*5] |-> $stable(LAMP_PWM) && !CONV_TRIG;
    endproperty
    a_fault: assert property (p_fault) else $error("pin moves under switch fault");
    property p_latch; COMP_OVER [*5] ##1 !WR [*8] |-> $stable(LAMP_PWM) && !CONV_TRIG; endproperty
    a_latch: assert property (p_latch) else $error("output back without a write");
    property p_stop;
        (STOP_MODE && SWITCH_FAULT_N && !COMP_OVER && !WR) [*6] |-> $stable(LAMP_PWM) && !CONV_TRIG;
    endproperty
    a_stop: assert property (p_stop) else $error("pwm runs in stop state");
    c_trig: cover property (CONV_TRIG);
    c_over: cover property (COMP_OVER [*5]);
    c_stop: cover property (STOP_MODE [*6]);
endmodule : lpc_sva

bind lpc_top lpc_sva lpc_sva_i (.CLK(CLK), .RST_B(RST_B), .WR(WR), .STOP_MODE(STOP_MODE),
    .SWITCH_FAULT_N(SWITCH_FAULT_N), .COMP_OVER(COMP_OVER), .LAMP_PWM(LAMP_PWM),
    .CONV_TRIG(CONV_TRIG), .CONV_CHAN(CONV_CHAN));

// File: verif/lpc_switch_model.sv
// high-side switch with bulb, its current comparator and the current converter
// assumes the bench sets the faults and the load; conv_lat sets the answer time
// ==================================================================
// model
module lpc_switch_model (
    input  wire logic       clk,            // system clock
    input  wire logic       rst_b,          // sync reset, active low
    input  wire logic       conv_trig,      // conversion start
    input  wire logic       inj_fault,      // switch failure present
    input  wire logic       inj_over,       // current above limit
    input  wire logic       load_ok,        // bulb fitted
    input  wire logic [7:0] conv_lat,       // conversion time
    output logic            switch_fault_n, // fault line, active low
    output logic            comp_over,      // comparator output
    output logic            conv_done,      // result pulse
    output logic      [7:0] conv_data       // result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    logic       busy_r;

    assign switch_fault_n = !inj_fault;
    assign comp_over      = inj_over;

    // data lines toggle outside the result cycle
    always_ff @(posedge clk)
    begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        cnt_r     <= cnt_r - 8'h01;
        if (!rst_b)
        begin
            busy_r    <= 1'b0;
            conv_data <= 8'h5a;
        end
        else if (conv_trig)
        begin
            busy_r <= 1'b1;
            cnt_r  <= conv_lat;
        end
        else if (busy_r && cnt_r == 8'h00)
        begin
            busy_r    <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= load_ok ? 8'hc0 : 8'h05;
        end
    end
endmodule : lpc_switch_model

// File: verif/lpc_top_tb.sv
// self-checking bench of the lamp pwm block with the switch model on its pins
// assumes lpc_regs.svh on the include path and the checker bound to lpc_top
`include "lpc_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end

module lpc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================================
    // signals and instances
    logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, stop_mode = 1'b0;
    logic        inj_fault = 1'b0, inj_over = 1'b0, load_ok = 1'b0;
    logic [7:0]  addr = 8'h00, conv_lat = 8'h14;
    logic [31:0] wdata = 32'h0, rdata;
    logic        irq, lamp_pwm, conv_trig, conv_done, fault_n, comp_over;
    logic [7:0]  conv_data;
    logic [2:0]  conv_chan;
    int          errors, n_checks;
    time         t1;

    lpc_top lpc_top_i (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .IRQ(irq), .STOP_MODE(stop_mode), .SWITCH_FAULT_N(fault_n),
        .COMP_OVER(comp_over), .LAMP_PWM(lamp_pwm), .CONV_TRIG(conv_trig),
        .CONV_CHAN(conv_chan), .CONV_DONE(conv_done), .CONV_DATA(conv_data));
    lpc_switch_model lpc_switch_model_i (.clk(clk), .rst_b(rst_b), .conv_trig(conv_trig),
        .inj_fault(inj_fault), .inj_over(inj_over), .load_ok(load_ok), .conv_lat(conv_lat),
        .switch_fault_n(fault_n), .comp_over(comp_over), .conv_done(conv_done),
        .conv_data(conv_data));

    always #4 clk = ~clk;

    // ==================================================================
    // bus and helpers
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    task automatic wait_pin(input logic lv);
        int n;
        n = 0;
        while (lamp_pwm !== lv && n < 70000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(lamp_pwm, lv)
    endtask : wait_pin

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // ==================================================================
    // scenarios
    task automatic t_reset();
        logic [31:0] d;
        logic [7:0]  a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18};
        logic [31:0] e [6] = '{32'h0, 32'h0, 32'h1, 32'h10, 32'h0, 32'h0};
        `CHK(lamp_pwm, 1'b1)
        `CHK(conv_chan, 3'h1)
        for (int i = 0; i < 6; i++)
        begin
            reg_rd(a[i], d);
            `CHK(d, e[i])
        end
        $display("reset test done");
    endtask : t_reset

    task automatic t_regs();
        logic [31:0] d;
        reg_wr(8'h04, 32'h1ff);
        reg_rd(8'h04, d);
        `CHK(d, 32'hff)
        reg_wr(8'h40, 32'hff);
        reg_rd(8'h40, d);
        `CHK(d, 32'h0)
        reg_wr(8'h10, 32'hff);
        reg_rd(8'h10, d);
        `CHK(d, 32'h0)
        $display("register test done");
    endtask : t_regs

    // one active period with a stop inside it, then the next period start
    task automatic t_pwm();
        logic [31:0] d1, d2, s;
        reg_wr(8'h00, 32'h2);
        reg_wr(8'h08, 32'h1);
        reg_wr(8'h04, 32'h8);
        wait_pin(1'b1);
        t1 = $time;
        reg_rd(8'h10, d1);
        repeat (50) @(posedge clk);
        stop_mode <= 1'b1;
        repeat (300)
        begin
            @(posedge clk);
            #1;
            `CHK(lamp_pwm, 1'b1)
        end
        stop_mode <= 1'b0;
        reg_rd(8'h1c, s);
        `CHK(s[23:0], 24'h000505)
        reg_rd(8'h14, s);
        `CHK(s[3:2], 2'b11)
        reg_rd(8'h10, s);
        `CHK(s[9], 1'b1)
        wait_pin(1'b0);
        wait_pin(1'b1);
        `CHK(($time - t1) / 8, 64'h7b2c)
        reg_rd(8'h10, d2);
        `CHK(d2[7:0], d1[7:0] + 8'h01)
        $display("pwm test done");
    endtask : t_pwm

    task automatic t_fault();
        logic [31:0] d;
        inj_fault <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(lamp_pwm, 1'b0)
        repeat (5) @(posedge clk);
        inj_fault <= 1'b0;
        repeat (10) @(posedge clk);
        reg_rd(8'h00, d);
        `CHK(d, 32'h3)
        reg_rd(8'h14, d);
        `CHK(d[1], 1'b1)
        $display("fault test done");
    endtask : t_fault

    task automatic t_over();
        logic [31:0] d;
        reg_wr(8'h14, 32'hf);
        reg_wr(8'h00, 32'h2);
        inj_over <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK(irq, 1'b0)
        reg_rd(8'h00, d);
        `CHK(d, 32'h3)
        reg_wr(8'h18, 32'h1);
        #1;
        `CHK(irq, 1'b1)
        reg_wr(8'h00, 32'h2);
        reg_rd(8'h00, d);
        `CHK(d, 32'h3)
        inj_over <= 1'b0;
        repeat (10) @(posedge clk);
        reg_wr(8'h14, 32'h1);
        #1;
        `CHK(irq, 1'b0)
        reg_wr(8'h00, 32'h2);
        reg_rd(8'h00, d);
        `CHK(d, 32'h2)
        reg_rd(8'h10, d);
        `CHK(d[7:0], 8'h00)
        $display("overcurrent test done");
    endtask : t_over

    // ==================================================================
    // sequence and watchdog
    initial
    begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_regs();
        t_pwm();
        t_fault();
        t_over();
        finish_test();
    end

    initial
    begin
        repeat (98000) @(posedge clk);
        $display("BAD %0t watchdog expired", $time);
        errors++;
        finish_test();
    end
endmodule : lpc_top_tb
